// ---- boot_mode_select.sv ----
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "boot_mode_select_cfg.svh"

module boot_mode_select #(
  parameter int PIN_COUNT = 256,
  parameter int OTP_DEPTH = 256
) (
  // clock and resets
  input wire logic clk,
  input wire logic resetn,
  input wire logic por_n,
  // boot environment
  input wire logic debugger_attached,
  input wire logic [PIN_COUNT-1:0] pin_levels,
  // storage programming port
  input wire logic otp_prog_en,
  input wire logic [7:0] otp_prog_addr,
  input wire logic [31:0] otp_prog_data,
  // boot results
  output logic global_interrupt_mask,
  output logic interrupt_expansion_block_disable,
  output logic [21:0] fetch_address,
  output logic reset_vector_fetch,
  output logic boot_done,
  output logic boot_waiting,
  output logic [3:0] boot_source,
  output logic [3:0] boot_options,
  output logic zone1_locked,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  boot_mode_select_pkg::boot_regs_t st;
  boot_mode_select_pkg::boot_regs_t next_st;
  logic [31:0] otp_rd_data;

  otp_store #(
    .DEPTH(OTP_DEPTH),
    .ADDR_W(8)
  ) u_otp (
    .clk(clk),
    .resetn(resetn),
    // next address, so the word stands in the cycle after the request
    .rd_addr(next_st.otp_addr),
    .rd_data(otp_rd_data),
    .prog_en(otp_prog_en),
    .prog_addr(otp_prog_addr),
    .prog_data(otp_prog_data)
  );

  function automatic logic [2:0] pin_index(
    input logic [31:0] pin_config,
    input logic [PIN_COUNT-1:0] levels
  );
    logic [2:0] idx;
    logic [1:0] pos;
    logic [7:0] sel;
    idx = 3'h0;
    pos = 2'h0;
    for (int f = 0; f < `SEL_FIELD_COUNT; f++)
    begin
      sel = pin_config[f*`SEL_FIELD_W +: `SEL_FIELD_W];
      if (sel != `SEL_UNUSED)
      begin
        // active pins packed in field order, first field lowest
        idx[pos] = (32'(sel) < PIN_COUNT) ? levels[sel] : 1'b0;
        pos = pos + 2'h1;
      end
    end
    return idx;
  endfunction : pin_index

  function automatic logic [7:0] def_select(
    input logic [31:0] low,
    input logic [31:0] high,
    input logic [2:0] idx
  );
    logic [63:0] both;
    both = {high, low};
    return both[idx*`DEF_FIELD_W +: `DEF_FIELD_W];
  endfunction : def_select

  function automatic logic [4:0] link_region(input logic [31:0] link);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < `OTP_LINK_BITS; i++)
    begin
      if (!link[i])
      begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : link_region

  function automatic logic [31:0] read_reg(
    input boot_mode_select_pkg::boot_regs_t s,
    input logic [7:0] a
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `OFS_EMU_PIN_CONFIG: v = s.emu_pin_config;
      `OFS_EMU_DEF_LOW: v = s.emu_def_low;
      `OFS_EMU_DEF_HIGH: v = s.emu_def_high;
      // zone-one contents hidden while the zone is locked
      `OFS_Z1_PIN_CONFIG: v = s.zone_locked ? 32'h0 : s.z1_pin_config;
      `OFS_Z1_DEF_LOW: v = s.zone_locked ? 32'h0 : s.z1_def_low;
      `OFS_Z1_DEF_HIGH: v = s.zone_locked ? 32'h0 : s.z1_def_high;
      `OFS_BOOT_STATUS: v = {7'h0, s.region, s.def_field, 1'b0,
                             s.boot_index, 1'b0, s.path, s.state};
      `OFS_FETCH_ADDRESS: v = {10'h0, s.fetch_address};
      `OFS_ZONE_STATUS: v = {31'h0, s.zone_locked};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_reg

  logic [31:0] z1_key;
  logic [31:0] emu_key;
  logic [7:0] region_base;
  logic addr_phase;
  logic [3:0][31:0] key_after;

  always_comb
  begin
    next_st = st;
    z1_key = {24'h0, st.z1_pin_config[`KEY_MSB:`KEY_LSB]};
    emu_key = {24'h0, st.emu_pin_config[`KEY_MSB:`KEY_LSB]};
    region_base = 8'(`OTP_REGION_BASE + 32'(st.region) * `OTP_REGION_WORDS);
    addr_phase = hsel && htrans[1] && hready;
    key_after = st.key;
    next_st.vector_fetch = 1'b0;

    // bus data phase: writes land one cycle after their address phase
    if (st.dphase_write)
    begin
      case (st.dphase_addr)
        `OFS_EMU_PIN_CONFIG: next_st.emu_pin_config = hwdata;
        `OFS_EMU_DEF_LOW: next_st.emu_def_low = hwdata;
        `OFS_EMU_DEF_HIGH: next_st.emu_def_high = hwdata;
        default: next_st.emu_pin_config = st.emu_pin_config;
      endcase
      if (st.dphase_addr >= `OFS_ZONE_KEY0 &&
          st.dphase_addr <= `OFS_ZONE_KEY3)
      begin
        key_after[st.dphase_addr[3:2]] = hwdata;
        next_st.key = key_after;
        // last key word decides: match unlocks, mismatch locks unless the password is blank
        if (st.dphase_addr == `OFS_ZONE_KEY3)
        begin
          next_st.zone_locked = (st.password != {4{`OTP_BLANK}}) &&
                                (key_after != st.password);
        end
      end
    end
    next_st.dphase_write = addr_phase && hwrite;
    next_st.dphase_addr = addr_phase ? haddr[7:0] : 8'h00;
    // read data registered in the address phase, valid in data phase
    next_st.hrdata = (addr_phase && !hwrite) ?
                     read_reg(st, haddr[7:0]) : 32'h0000_0000;

    case (st.state)
      boot_mode_select_pkg::ST_VECTOR:
      begin
        next_st.fetch_address = `RESET_ADDRESS;
        next_st.vector_fetch = 1'b1;
        next_st.otp_addr = `OTP_LINK_ADDR;
        next_st.state = boot_mode_select_pkg::ST_LINK;
      end
      boot_mode_select_pkg::ST_LINK:
      begin
        next_st.state = boot_mode_select_pkg::ST_LINK_WAIT;
      end
      boot_mode_select_pkg::ST_LINK_WAIT:
      begin
        next_st.region = link_region(otp_rd_data);
        next_st.word_idx = 3'h0;
        next_st.state = boot_mode_select_pkg::ST_ISSUE;
      end
      boot_mode_select_pkg::ST_ISSUE:
      begin
        next_st.otp_addr = region_base + {5'h00, st.word_idx};
        next_st.state = boot_mode_select_pkg::ST_CAPTURE;
      end
      boot_mode_select_pkg::ST_CAPTURE:
      begin
        // one read in flight at a time; slower but no pipeline hazards
        if (st.word_idx < `OTP_PIN_WORD)
        begin
          next_st.password[st.word_idx[1:0]] = otp_rd_data;
        end
        else if (st.word_idx == `OTP_PIN_WORD)
        begin
          next_st.z1_pin_config = otp_rd_data;
        end
        else if (st.word_idx == `OTP_DEF_LOW_WORD)
        begin
          next_st.z1_def_low = otp_rd_data;
        end
        else
        begin
          next_st.z1_def_high = otp_rd_data;
        end
        if (st.word_idx == `OTP_LAST_WORD)
        begin
          // blank password means unlocked after reset
          next_st.zone_locked = (st.password != {4{`OTP_BLANK}});
          next_st.state = boot_mode_select_pkg::ST_DECIDE;
        end
        else
        begin
          next_st.word_idx = st.word_idx + 3'h1;
          next_st.state = boot_mode_select_pkg::ST_ISSUE;
        end
      end
      boot_mode_select_pkg::ST_DECIDE:
      begin
        next_st.state = boot_mode_select_pkg::ST_DONE;
        if (debugger_attached && emu_key == 32'(`KEY_CUSTOM))
        begin
          next_st.path = boot_mode_select_pkg::PATH_EMULATION;
          next_st.boot_index = pin_index(st.emu_pin_config, pin_levels);
          next_st.def_field = def_select(st.emu_def_low, st.emu_def_high,
                                         next_st.boot_index);
        end
        else if (debugger_attached &&
                 emu_key != 32'(`KEY_EMU_STANDALONE))
        begin
          next_st.path = boot_mode_select_pkg::PATH_EMULATION;
          next_st.state = boot_mode_select_pkg::ST_WAIT;
        end
        else if (z1_key == 32'(`KEY_CUSTOM))
        begin
          // key A5 replays the whole stand-alone choice under the debugger
          next_st.path = debugger_attached ?
                         boot_mode_select_pkg::PATH_EMU_STANDALONE :
                         boot_mode_select_pkg::PATH_ZONE1;
          next_st.boot_index = pin_index(st.z1_pin_config, pin_levels);
          next_st.def_field = def_select(st.z1_def_low, st.z1_def_high,
                                         next_st.boot_index);
        end
        else
        begin
          // default pins b:a give the four fixed choices
          next_st.path = boot_mode_select_pkg::PATH_DEFAULT_PINS;
          next_st.boot_index = {1'b0, pin_levels[`DEFAULT_PIN_B],
                                pin_levels[`DEFAULT_PIN_A]};
          case ({pin_levels[`DEFAULT_PIN_B], pin_levels[`DEFAULT_PIN_A]})
            2'b00: next_st.def_field = `CHOICE_PARALLEL;
            2'b01: next_st.def_field = `CHOICE_SERIAL_WAIT;
            2'b10: next_st.def_field = `CHOICE_CAN;
            default: next_st.def_field = `CHOICE_FLASH;
          endcase
        end
      end
      boot_mode_select_pkg::ST_WAIT:
      begin
        // only a reset leaves wait mode
        next_st.state = boot_mode_select_pkg::ST_WAIT;
      end
      boot_mode_select_pkg::ST_DONE:
      begin
        next_st.state = boot_mode_select_pkg::ST_DONE;
      end
      default:
      begin
        next_st.state = boot_mode_select_pkg::ST_VECTOR;
      end
    endcase

    // emulation words live through device reset, cleared only at power-on
    if (!resetn)
    begin
      next_st.state = boot_mode_select_pkg::ST_VECTOR;
      next_st.z1_pin_config = 32'h0000_0000;
      next_st.z1_def_low = 32'h0000_0000;
      next_st.z1_def_high = 32'h0000_0000;
      next_st.password = {4{`OTP_BLANK}};
      next_st.key = '0;
      next_st.zone_locked = 1'b0;
      next_st.region = 5'h00;
      next_st.word_idx = 3'h0;
      next_st.otp_addr = 8'h00;
      next_st.path = boot_mode_select_pkg::PATH_NONE;
      next_st.boot_index = 3'h0;
      next_st.def_field = 8'h00;
      next_st.vector_fetch = 1'b0;
      next_st.fetch_address = `RESET_ADDRESS;
      next_st.dphase_write = 1'b0;
      next_st.dphase_addr = 8'h00;
      next_st.hrdata = 32'h0000_0000;
    end
    if (!por_n)
    begin
      next_st.emu_pin_config = `EMU_WORD_RESET;
      next_st.emu_def_low = `EMU_WORD_RESET;
      next_st.emu_def_high = `EMU_WORD_RESET;
    end
  end

  always_ff @(posedge clk)
  begin
    st <= next_st;
  end

  // interrupts stay off until the boot choice is final
  assign global_interrupt_mask =
    (st.state != boot_mode_select_pkg::ST_DONE);
  assign interrupt_expansion_block_disable =
    (st.state != boot_mode_select_pkg::ST_DONE);
  assign fetch_address = st.fetch_address;
  assign reset_vector_fetch = st.vector_fetch;
  assign boot_done = (st.state == boot_mode_select_pkg::ST_DONE);
  assign boot_waiting = (st.state == boot_mode_select_pkg::ST_WAIT);
  assign boot_source = st.def_field[`DEF_MODE_MSB:0];
  assign boot_options = st.def_field[7:`DEF_OPT_LSB];
  assign zone1_locked = st.zone_locked;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;

endmodule : boot_mode_select
`default_nettype wire

// ---- boot_mode_select_cfg.svh ----
`ifndef BOOT_MODE_SELECT_CFG_SVH
`define BOOT_MODE_SELECT_CFG_SVH

// register byte offsets
`define OFS_EMU_PIN_CONFIG 8'h00
`define OFS_EMU_DEF_LOW 8'h04
`define OFS_EMU_DEF_HIGH 8'h08
`define OFS_Z1_PIN_CONFIG 8'h0C
`define OFS_Z1_DEF_LOW 8'h10
`define OFS_Z1_DEF_HIGH 8'h14
`define OFS_BOOT_STATUS 8'h18
`define OFS_FETCH_ADDRESS 8'h1C
`define OFS_ZONE_KEY0 8'h20
`define OFS_ZONE_KEY3 8'h2C
`define OFS_ZONE_STATUS 8'h30
`define REG_SPAN 8'h34

// reset values
`define EMU_WORD_RESET 32'h0000_0000
`define RESET_ADDRESS 22'h3F_FFC0

// pin-configuration word layout
`define KEY_MSB 31
`define KEY_LSB 24
`define SEL_FIELD_W 8
`define SEL_FIELD_COUNT 3
`define SEL_UNUSED 8'hFF
`define KEY_CUSTOM 8'h5A
`define KEY_EMU_STANDALONE 8'hA5

// boot-definition field layout
`define DEF_FIELD_W 8
`define DEF_MODE_MSB 3
`define DEF_OPT_LSB 4

// default two-pin choices
`define DEFAULT_PIN_A 24
`define DEFAULT_PIN_B 32
`define CHOICE_PARALLEL 8'h00
`define CHOICE_SERIAL_WAIT 8'h01
`define CHOICE_CAN 8'h02
`define CHOICE_FLASH 8'h03

// one-time-programmable storage layout, in words
`define OTP_LINK_ADDR 8'h00
`define OTP_REGION_BASE 1
`define OTP_REGION_WORDS 7
`define OTP_LINK_BITS 30
`define OTP_PIN_WORD 3'h4
`define OTP_DEF_LOW_WORD 3'h5
`define OTP_LAST_WORD 3'h6
`define OTP_BLANK 32'hFFFF_FFFF

`endif

// ---- boot_mode_select_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module boot_mode_select_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // boot results
  input wire logic global_interrupt_mask,
  input wire logic interrupt_expansion_block_disable,
  input wire logic [21:0] fetch_address,
  input wire logic reset_vector_fetch,
  input wire logic boot_done,
  input wire logic boot_waiting,
  input wire logic [3:0] boot_source,
  input wire logic [3:0] boot_options,
  input wire logic zone1_locked,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic rd;
  assign rd = hsel && htrans[1] && hready && !hwrite;
  a_mask_in_boot:
    assert property (global_interrupt_mask == !boot_done &&
      interrupt_expansion_block_disable == global_interrupt_mask)
    else $error("interrupt mask wrong");
  a_fetch_at_start:
    assert property ($rose(resetn) |-> fetch_address == 22'h3FFFC0)
    else $error("fetch address wrong");
  a_vector_after_rst:
    assert property ($rose(resetn) |-> ##[0:2] reset_vector_fetch)
    else $error("no vector fetch");
  a_vector_single:
    assert property (reset_vector_fetch |=> !reset_vector_fetch)
    else $error("vector pulse too long");
  a_done_in_time:
    assert property ($rose(resetn) |-> ##[1:40] (boot_done || boot_waiting))
    else $error("boot never ends");
  a_one_outcome:
    assert property (!(boot_done && boot_waiting))
    else $error("done and waiting");
  a_wait_holds:
    assert property (boot_waiting |=> boot_waiting)
    else $error("wait left without reset");
  a_result_stable:
    assert property (boot_done |=> $stable({boot_options, boot_source}))
    else $error("boot result moved");
  a_bus_okay:
    assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  a_locked_hides:
    assert property (rd && zone1_locked &&
      haddr[7:0] inside {8'h0C, 8'h10, 8'h14} |=> hrdata == 32'h0)
    else $error("locked word visible");
  a_keys_unread:
    assert property (rd && haddr[7:0] inside {8'h20, 8'h24, 8'h28, 8'h2C}
      |=> hrdata == 32'h0)
    else $error("key word readable");
endmodule : boot_mode_select_monitor
bind boot_mode_select boot_mode_select_monitor mon (
  .clk(clk), .resetn(resetn),
  .global_interrupt_mask(global_interrupt_mask),
  .interrupt_expansion_block_disable(interrupt_expansion_block_disable),
  .fetch_address(fetch_address), .reset_vector_fetch(reset_vector_fetch),
  .boot_done(boot_done), .boot_waiting(boot_waiting),
  .boot_source(boot_source), .boot_options(boot_options),
  .zone1_locked(zone1_locked), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
);
`default_nettype wire

// ---- boot_mode_select_pkg.sv ----
package boot_mode_select_pkg;

  typedef enum logic [3:0] {
    ST_VECTOR,
    ST_LINK,
    ST_LINK_WAIT,
    ST_ISSUE,
    ST_CAPTURE,
    ST_DECIDE,
    ST_WAIT,
    ST_DONE
  } boot_state_t;

  typedef enum logic [2:0] {
    PATH_NONE,
    PATH_EMULATION,
    PATH_EMU_STANDALONE,
    PATH_ZONE1,
    PATH_DEFAULT_PINS
  } boot_path_t;

  typedef struct packed {
    boot_state_t state;
    logic [31:0] emu_pin_config;
    logic [31:0] emu_def_low;
    logic [31:0] emu_def_high;
    logic [31:0] z1_pin_config;
    logic [31:0] z1_def_low;
    logic [31:0] z1_def_high;
    logic [3:0][31:0] password;
    logic [3:0][31:0] key;
    logic zone_locked;
    logic [4:0] region;
    logic [2:0] word_idx;
    logic [7:0] otp_addr;
    boot_path_t path;
    logic [2:0] boot_index;
    logic [7:0] def_field;
    logic vector_fetch;
    logic [21:0] fetch_address;
    logic dphase_write;
    logic [7:0] dphase_addr;
    logic [31:0] hrdata;
  } boot_regs_t;

endpackage : boot_mode_select_pkg

// ---- boot_mode_select_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module boot_mode_select_test;
  logic clk = 1'b0;
  logic resetn, por_n, debugger_attached, hsel, hwrite;
  logic [255:0] pin_levels, p;
  logic otp_prog_en;
  logic [7:0] otp_prog_addr;
  logic [31:0] otp_prog_data, haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic global_interrupt_mask, interrupt_expansion_block_disable;
  logic [21:0] fetch_address;
  logic reset_vector_fetch, boot_done, boot_waiting, zone1_locked;
  logic [3:0] boot_source, boot_options;
  logic hreadyout, hresp;
  int n_errors = 0;
  int n_compared = 0;
  int emu[3], z[3], pw[4];
  always #20 clk = ~clk;
  otp_programmer prog (
    .clk(clk), .otp_prog_en(otp_prog_en), .otp_prog_addr(otp_prog_addr),
    .otp_prog_data(otp_prog_data)
  );
  boot_mode_select dut (
    .clk(clk), .resetn(resetn), .por_n(por_n),
    .debugger_attached(debugger_attached), .pin_levels(pin_levels),
    .otp_prog_en(otp_prog_en), .otp_prog_addr(otp_prog_addr),
    .otp_prog_data(otp_prog_data),
    .global_interrupt_mask(global_interrupt_mask),
    .interrupt_expansion_block_disable(interrupt_expansion_block_disable),
    .fetch_address(fetch_address), .reset_vector_fetch(reset_vector_fetch),
    .boot_done(boot_done), .boot_waiting(boot_waiting),
    .boot_source(boot_source), .boot_options(boot_options),
    .zone1_locked(zone1_locked), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata)
  );

  task automatic wrap_up();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask : wr

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask : chk_rd

  function automatic logic [7:0] fld();
    return $urandom_range(3) == 0 ? 8'hFF : 8'($urandom);
  endfunction : fld

  // first active field lands in index bit zero
  function automatic int pick(int c, int lo, int hi);
    int j;
    int x;
    longint d;
    j = 0;
    x = 0;
    d = {hi, lo};
    for (int f = 0; f < 3; f++)
      if (c[8*f +: 8] != 8'hFF)
      begin
        x = x | (pin_levels[c[8*f +: 8]] << j);
        j++;
      end
    return d[8*x +: 8];
  endfunction : pick

  // -1 stands for the wait outcome
  function automatic int model();
    int k;
    k = emu[0][31:24];
    if (debugger_attached && k != 8'h5A && k != 8'hA5)
      return -1;
    if (debugger_attached && k == 8'h5A)
      return pick(emu[0], emu[1], emu[2]);
    if (z[0][31:24] != 8'h5A)
      return {pin_levels[32], pin_levels[24]};
    return pick(z[0], z[1], z[2]);
  endfunction : model

  task automatic put(input int r);
    prog.load(r, {z[2], z[1], z[0], pw[3], pw[2], pw[1], pw[0]});
  endtask : put

  task automatic boot(input bit por, input logic [255:0] pins);
    int f;
    int n;
    @(posedge clk);
    resetn <= 1'b0;
    por_n <= ~por;
    pin_levels <= pins;
    if (por)
      emu = '{0, 0, 0};
    repeat (12) @(posedge clk);
    chk(global_interrupt_mask, 1'b1);
    chk(interrupt_expansion_block_disable, 1'b1);
    chk(fetch_address, 22'h3FFFC0);
    resetn <= 1'b1;
    por_n <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (boot_done !== 1'b1 && boot_waiting !== 1'b1 && n < 99);
    f = model();
    if (f < 0)
      chk(boot_waiting, 1'b1);
    else
    begin
      chk(boot_done, 1'b1);
      chk({boot_options, boot_source}, f);
      chk(zone1_locked, (pw[0] & pw[1] & pw[2] & pw[3]) != -1);
    end
  endtask : boot

  initial
  begin
    resetn = 1'b0;
    por_n = 1'b0;
    debugger_attached = 1'b0;
    pin_levels = '0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    rd = $urandom(32437);
    pw = '{-1, -1, -1, -1};
    z = '{$urandom & 32'h00FFFFFF, $urandom, $urandom};
    put(0);
    for (int c = 0; c < 4; c++)
    begin
      p = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
        $urandom, $urandom};
      p[24] = c[0];
      p[32] = c[1];
      boot(c == 0, p);
    end
    chk_rd(8'h0C, z[0]);
    wr(8'h0C, 32'h5A000000);
    chk_rd(8'h0C, z[0]);
    chk_rd(8'h1C, 32'h003FFFC0);
    chk_rd(8'h40, 32'h0);
    for (int r = 1; r < 7; r++)
    begin
      z = '{r == 1 ? 32'h5AFFFFFF : {8'h5A, fld(), fld(), fld()},
        $urandom, $urandom};
      put(r);
      p = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
        $urandom, $urandom};
      boot(1'b0, p);
      ahb(1'b0, 8'h18, 32'h0, rd);
      chk(rd[24:20], r);
    end
    @(posedge clk);
    debugger_attached <= 1'b1;
    boot(1'b1, p);
    emu = '{{8'h5A, fld(), fld(), fld()}, $urandom, $urandom};
    for (int i = 0; i < 3; i++)
      wr(8'(4 * i), emu[i]);
    boot(1'b0, ~p);
    emu[0][31:24] = 8'hA5;
    wr(8'h00, emu[0]);
    chk_rd(8'h00, emu[0]);
    boot(1'b0, p);
    @(posedge clk);
    debugger_attached <= 1'b0;
    pw = '{$urandom, $urandom, $urandom, $urandom};
    z = '{{8'h5A, fld(), fld(), fld()}, $urandom, $urandom};
    put(7);
    boot(1'b0, p);
    chk_rd(8'h0C, 32'h0);
    for (int i = 0; i < 4; i++)
      wr(8'(32 + 4 * i), pw[i]);
    chk_rd(8'h30, 32'h0);
    chk_rd(8'h20, 32'h0);
    chk_rd(8'h0C, z[0]);
    wr(8'h2C, ~pw[3]);
    chk_rd(8'h30, 32'h1);
    wrap_up();
  end

  // fourteen boots of some thirty cycles each, with ample margin
  initial
  begin
    #1000000;
    n_errors++;
    wrap_up();
  end
endmodule : boot_mode_select_test
`default_nettype wire

// ---- otp_programmer.sv ----
`timescale 1ns/1ps
`default_nettype none
module otp_programmer (
  // clock
  input wire logic clk,
  // storage programming port
  output logic otp_prog_en,
  output logic [7:0] otp_prog_addr,
  output logic [31:0] otp_prog_data
);
  initial
  begin
    otp_prog_en = 1'b0;
    otp_prog_addr = 8'h00;
    otp_prog_data = 32'h0;
  end
  // a fresh region per configuration, since storage never erases
  task automatic load(input int r, input logic [6:0][31:0] w);
    @(posedge clk);
    otp_prog_en <= 1'b1;
    otp_prog_addr <= 8'h00;
    // clearing bits r..0 makes bit r the highest zero
    otp_prog_data <= 32'hFFFFFFFF << (r + 1);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk);
      otp_prog_addr <= 8'(1 + 7 * r + i);
      otp_prog_data <= w[i];
    end
    @(posedge clk);
    otp_prog_en <= 1'b0;
    otp_prog_data <= ~w[6];
  endtask : load
endmodule : otp_programmer
`default_nettype wire

// ---- otp_store.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "boot_mode_select_cfg.svh"

module otp_store #(
  parameter int DEPTH = 256,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // read port
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [31:0] rd_data,
  // programming port: bits can only go from one to zero
  input wire logic prog_en,
  input wire logic [ADDR_W-1:0] prog_addr,
  input wire logic [31:0] prog_data
);

  typedef struct packed {
    logic [DEPTH-1:0][31:0] mem;
    logic [31:0] rdata;
  } otp_regs_t;

  // blank storage reads all ones; no reset may erase it
  otp_regs_t st = '{mem: '1, rdata: 32'h0000_0000};
  otp_regs_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.rdata = st.mem[rd_addr];
    if (prog_en)
    begin
      next_st.mem[prog_addr] = st.mem[prog_addr] & prog_data;
    end
  end

  // storage is not erased by reset; reset only clears the read register
  always_ff @(posedge clk)
  begin
    st.mem <= next_st.mem;
    if (!resetn)
    begin
      st.rdata <= 32'h0000_0000;
    end
    else
    begin
      st.rdata <= next_st.rdata;
    end
  end

  assign rd_data = st.rdata;

endmodule : otp_store
`default_nettype wire
